// File: core/rpf_pkg.sv
// Package: constants, carriers and helpers of the register parity failsafe monitor
package rpf_pkg;
	// Register word indices; byte address is four times the index
	localparam logic [7:0] IDX_TRANSMITTER_STATUS_REGISTER = 8'h01;
	localparam logic [7:0] IDX_CFG0 = 8'h10;
	localparam logic [7:0] IDX_CFGEND = 8'h18;
	localparam logic [7:0] IDX_MASK = 8'h20;
	localparam logic [7:0] IDX_CTRL = 8'h21;
	localparam logic [7:0] IDX_PARITY = 8'h22;
	localparam int CFG_COUNT = 8;
	localparam int IDX_W = 3;
	// Transmitter status register fields
	localparam int BIT_PLL = 0;
	localparam int BIT_PAR = 1;
	localparam int BIT_BRN = 2;
	localparam int BIT_VCO = 3;
	localparam int BIT_LBD24 = 4;
	localparam int BIT_LBD21 = 5;
	localparam logic [7:0] STAT_RESET = 8'h04;
	localparam logic [7:0] STAT_FIXED = 8'h80;
	localparam logic [7:0] FAIL_MASK = 8'h0F;
	localparam logic [7:0] LBD_MASK = 8'h30;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int CTRL_TX = 0;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [1:0] WORD_ALIGN = 2'h0;
	localparam logic [1:0] ADDR_TOP_ZERO = 2'h0;

	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} rpf_apb_req_t;

	typedef struct packed {
		logic pllLockLost;
		logic vcoCalFail;
		logic brownout;
		logic lbd24Low;
		logic lbd21Low;
	} rpf_supply_ev_t;

	function automatic logic byteParity(input logic [7:0] d);
		return ^d;
	endfunction
endpackage

// File: core/rpf_status_flags.sv
// Sticky transmitter status flags with mask and interrupt output
`timescale 1ns/100ps
`default_nettype none
module rpf_status_flags (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Hardware events, one bit per status field
	input wire logic [7:0] setEv,
	input wire logic brownout,
	input wire logic lbdClear,
	// Software access
	input wire logic w1cStrobe,
	input wire logic [7:0] w1cData,
	input wire logic [7:0] maskReg,
	// State
	output logic [7:0] statusReg,
	output logic irq
);
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [7:0] clrBits;

	always_comb begin
		clrBits = rpf_pkg::ZERO_BYTE;
		if (w1cStrobe) begin
			clrBits = w1cData & rpf_pkg::FAIL_MASK;
		end
		// Battery flags are read-only; a transmission start clears them
		if (lbdClear) begin
			clrBits = clrBits | rpf_pkg::LBD_MASK;
		end
		// A new event wins over a clear in the same cycle
		status_next = (status_reg & ~clrBits) | setEv | rpf_pkg::STAT_FIXED;
	end

	always_ff @(posedge mclk) begin
		if (reset || brownout) begin
			status_reg <= rpf_pkg::STAT_RESET | rpf_pkg::STAT_FIXED;
		end else begin
			status_reg <= status_next;
		end
	end

	assign statusReg = status_reg;
	assign irq = |(status_reg & maskReg & ~rpf_pkg::STAT_FIXED);
endmodule
`default_nettype wire

// File: core/rpf_parity_scan.sv
// Round-robin parity re-check of the configuration registers
`timescale 1ns/100ps
`default_nettype none
module rpf_parity_scan (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Control
	input wire logic scanEnable,
	// Register under test
	output logic [rpf_pkg::IDX_W-1:0] scanIdx,
	input wire logic [7:0] cfgData,
	input wire logic cfgParity,
	// Result
	output logic mismatch
);
	typedef enum logic [0:0] {
		SCAN_IDLE = 1'b0,
		SCAN_RUN = 1'b1
	} rpf_scan_state_t;

	rpf_scan_state_t state_reg;
	logic [rpf_pkg::IDX_W-1:0] idx_reg;
	logic mismatch_reg;

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= SCAN_IDLE;
		end else begin
			case (state_reg)
				SCAN_IDLE: if (scanEnable) state_reg <= SCAN_RUN;
				SCAN_RUN: if (!scanEnable) state_reg <= SCAN_IDLE;
				default: state_reg <= SCAN_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || !scanEnable) begin
			idx_reg <= '0;
		end else if (state_reg == SCAN_RUN) begin
			idx_reg <= idx_reg + 1'b1;
		end
	end

	// Scan stops at once when the transmitter leaves its active state
	always_ff @(posedge mclk) begin
		if (reset) begin
			mismatch_reg <= 1'b0;
		end else begin
			mismatch_reg <= scanEnable && state_reg == SCAN_RUN &&
				rpf_pkg::byteParity(cfgData) != cfgParity;
		end
	end

	assign scanIdx = idx_reg;
	assign mismatch = mismatch_reg;

	scanStep_a: assert property (@(posedge mclk) disable iff (reset)
		state_reg == SCAN_RUN && scanEnable |=>
		idx_reg == rpf_pkg::IDX_W'($past(idx_reg) + 1'b1))
		else $error("scan index did not advance");
endmodule
`default_nettype wire

// File: core/rpf_failsafe_monitor.sv
// Register parity failsafe monitor with APB register access
// Contract
// - Status reports brownout, PLL, VCO, parity failures
// - Register write stores its fresh parity bit
// - Active transmitter keeps re-checking all parity
// - Parity mismatch raises the parity error flag
// - Any failure switches the power amplifier off
// - Brownout turns amplifier off without host
// - Battery-low and brownout flags follow supply events; battery-low flags set only while transmitting
// - Brownout shows in status bit two
// - Brownout resets configuration and restarts from reset
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module rpf_failsafe_monitor (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Supply and synthesizer monitors
	input wire logic pllLockLost,
	input wire logic vcoCalFail,
	input wire logic brownout,
	input wire logic lbd24Low,
	input wire logic lbd21Low,
	// Upset path: flips stored bits without a write
	input wire logic upsetStrobe,
	input wire logic [rpf_pkg::IDX_W-1:0] upsetIndex,
	input wire logic [7:0] upsetBits,
	// Transmitter control
	output logic txActive,
	output logic paEnable,
	output logic irq
);
	rpf_pkg::rpf_apb_req_t req;
	rpf_pkg::rpf_supply_ev_t sup;
	logic [7:0] cfgMem [rpf_pkg::CFG_COUNT];
	logic [rpf_pkg::CFG_COUNT-1:0] parMem;
	logic [7:0] wordIdx;
	logic [rpf_pkg::IDX_W-1:0] cfgIdx;
	logic [rpf_pkg::IDX_W-1:0] scanIdx;
	logic aligned;
	logic isCfg;
	logic mapped;
	logic wrEn;
	logic wrCfg;
	logic parMismatch;
	logic txStart;
	logic anyFail;
	logic [7:0] setEv;
	logic [7:0] statusReg;
	logic [7:0] mask_reg;
	logic txActive_reg;
	logic paEnable_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rdata_next;

	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
	assign sup = '{pllLockLost: pllLockLost, vcoCalFail: vcoCalFail, brownout: brownout,
		lbd24Low: lbd24Low, lbd21Low: lbd21Low};

	// Address decode
	assign wordIdx = req.addr[9:2];
	assign aligned = req.addr[1:0] == rpf_pkg::WORD_ALIGN &&
		req.addr[11:10] == rpf_pkg::ADDR_TOP_ZERO;
	assign isCfg = wordIdx >= rpf_pkg::IDX_CFG0 && wordIdx < rpf_pkg::IDX_CFGEND;
	assign cfgIdx = rpf_pkg::IDX_W'(wordIdx - rpf_pkg::IDX_CFG0);
	assign mapped = aligned && (isCfg || wordIdx == rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER ||
		wordIdx == rpf_pkg::IDX_MASK || wordIdx == rpf_pkg::IDX_CTRL ||
		wordIdx == rpf_pkg::IDX_PARITY);
	assign wrEn = req.sel && req.enable && req.write && mapped;
	assign wrCfg = wrEn && isCfg;

	// Zero wait states; unmapped or misaligned accesses answer with an error
	assign pready = req.sel && req.enable;
	assign pslverr = req.sel && req.enable && !mapped;
	assign prdata = prdata_reg;

	// Configuration bank: a write stores data and its parity together
	always_ff @(posedge mclk) begin
		if (reset || sup.brownout) begin
			for (int i = 0; i < rpf_pkg::CFG_COUNT; i++) begin
				cfgMem[i] <= rpf_pkg::CFG_RESET;
				parMem[i] <= rpf_pkg::byteParity(rpf_pkg::CFG_RESET);
			end
		end else if (wrCfg) begin
			cfgMem[cfgIdx] <= req.wdata[7:0];
			parMem[cfgIdx] <= rpf_pkg::byteParity(req.wdata[7:0]);
		end else if (upsetStrobe) begin
			// Stands for a disturbed bit cell: content moves, parity does not
			cfgMem[upsetIndex] <= cfgMem[upsetIndex] ^ upsetBits;
		end
	end

	// Interrupt mask
	always_ff @(posedge mclk) begin
		if (reset || sup.brownout) begin
			mask_reg <= rpf_pkg::MASK_RESET;
		end else if (wrEn && wordIdx == rpf_pkg::IDX_MASK) begin
			mask_reg <= req.wdata[7:0];
		end
	end

	// Transmitter active state
	assign txStart = wrEn && wordIdx == rpf_pkg::IDX_CTRL &&
		req.wdata[rpf_pkg::CTRL_TX] && !txActive_reg;

	always_ff @(posedge mclk) begin
		if (reset || sup.brownout) begin
			txActive_reg <= 1'b0;
		end else if (wrEn && wordIdx == rpf_pkg::IDX_CTRL) begin
			txActive_reg <= req.wdata[rpf_pkg::CTRL_TX];
		end
	end

	// Failure events; battery thresholds only count while transmitting
	always_comb begin
		setEv = rpf_pkg::ZERO_BYTE;
		setEv[rpf_pkg::BIT_PLL] = sup.pllLockLost;
		setEv[rpf_pkg::BIT_VCO] = sup.vcoCalFail;
		setEv[rpf_pkg::BIT_PAR] = parMismatch;
		setEv[rpf_pkg::BIT_BRN] = sup.brownout;
		setEv[rpf_pkg::BIT_LBD24] = sup.lbd24Low && txActive_reg;
		setEv[rpf_pkg::BIT_LBD21] = sup.lbd21Low && txActive_reg;
	end

	rpf_status_flags statusFlags (
		.mclk(mclk),
		.reset(reset),
		.setEv(setEv),
		.brownout(sup.brownout),
		.lbdClear(txStart),
		.w1cStrobe(wrEn && wordIdx == rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER),
		.w1cData(req.wdata[7:0]),
		.maskReg(mask_reg),
		.statusReg(statusReg),
		.irq(irq)
	);

	rpf_parity_scan parityScan (
		.mclk(mclk),
		.reset(reset || sup.brownout),
		.scanEnable(txActive_reg),
		.scanIdx(scanIdx),
		.cfgData(cfgMem[scanIdx]),
		.cfgParity(parMem[scanIdx]),
		.mismatch(parMismatch)
	);

	// Amplifier stays off while any failure flag stands, and drops in the
	// same edge as a fresh event so no symbol leaves on a bad setting
	assign anyFail = |(statusReg & rpf_pkg::FAIL_MASK) || sup.brownout ||
		sup.pllLockLost || sup.vcoCalFail || parMismatch;

	always_ff @(posedge mclk) begin
		if (reset || sup.brownout) begin
			paEnable_reg <= 1'b0;
		end else begin
			paEnable_reg <= txActive_reg && !anyFail;
		end
	end

	assign txActive = txActive_reg;
	assign paEnable = paEnable_reg;

	// Read data is captured in the setup cycle
	always_comb begin
		rdata_next = rpf_pkg::ZERO_WORD;
		if (aligned) begin
			if (isCfg) begin
				rdata_next[7:0] = cfgMem[cfgIdx];
			end else begin
				case (wordIdx)
					rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER: rdata_next[7:0] = statusReg;
					rpf_pkg::IDX_MASK: rdata_next[7:0] = mask_reg;
					rpf_pkg::IDX_CTRL: rdata_next[rpf_pkg::CTRL_TX] = txActive_reg;
					rpf_pkg::IDX_PARITY: rdata_next[rpf_pkg::CFG_COUNT-1:0] = parMem;
					default: rdata_next = rpf_pkg::ZERO_WORD;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			prdata_reg <= rpf_pkg::ZERO_WORD;
		end else if (req.sel && !req.enable && !req.write) begin
			prdata_reg <= rdata_next;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	sequence cfgWrite_s;
		wrCfg && !sup.brownout;
	endsequence

	sequence brownHit_s;
		sup.brownout;
	endsequence

	sequence statRead_s;
		req.sel && !req.enable && !req.write && aligned && wordIdx == rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER;
	endsequence

	parityStore_a: assert property (cfgWrite_s |=>
		parMem[$past(cfgIdx)] == ^$past(req.wdata[7:0]))
		else $error("stored parity does not match written byte");

	parityFlag_a: assert property (parMismatch && !sup.brownout |=>
		statusReg[rpf_pkg::BIT_PAR])
		else $error("parity mismatch did not set the flag");

	failureFlags_a: assert property ((sup.vcoCalFail || sup.pllLockLost) &&
		!sup.brownout |=> statusReg[rpf_pkg::BIT_VCO] == $past(sup.vcoCalFail) &&
		statusReg[rpf_pkg::BIT_PLL] == $past(sup.pllLockLost) ||
		statusReg[rpf_pkg::BIT_VCO] && statusReg[rpf_pkg::BIT_PLL])
		else $error("failure event not recorded");

	paBlocked_a: assert property (|(statusReg & rpf_pkg::FAIL_MASK) |-> !paEnable_reg)
		else $error("amplifier on while a failure flag is set");

	brownPaOff_a: assert property (brownHit_s |=> !paEnable_reg[*2])
		else $error("amplifier not off after brownout");

	batteryFlag_a: assert property (txActive_reg && sup.lbd21Low && !sup.brownout |=>
		statusReg[rpf_pkg::BIT_LBD21])
		else $error("battery low flag not set");

	brownBit_a: assert property (statRead_s ##1 req.sel && req.enable |->
		prdata_reg[rpf_pkg::BIT_BRN] == $past(statusReg[rpf_pkg::BIT_BRN]))
		else $error("status read lost the brownout bit");

	brownRestart_a: assert property (brownHit_s |=>
		cfgMem[0] == rpf_pkg::CFG_RESET && !txActive_reg &&
		statusReg[rpf_pkg::BIT_BRN] && mask_reg == rpf_pkg::MASK_RESET)
		else $error("brownout did not restart the register bank");

	// A scan step needs two active cycles: the scanner starts one edge late
	sequence scanRun_s;
		txActive_reg && $past(txActive_reg) && !sup.brownout;
	endsequence

	sequence refused_s;
		req.sel && req.enable && !mapped && !sup.brownout;
	endsequence

	brownParity_a: assert property (brownHit_s |=>
		parMem == {rpf_pkg::CFG_COUNT{rpf_pkg::byteParity(rpf_pkg::CFG_RESET)}})
		else $error("brownout did not reset the parity bank");

	upsetParity_a: assert property (upsetStrobe && !wrCfg && !sup.brownout |=>
		$stable(parMem))
		else $error("parity changed without a register write");

	scanWalk_a: assert property (scanRun_s |=>
		scanIdx == rpf_pkg::IDX_W'($past(scanIdx) + 1'b1))
		else $error("active transmitter stopped the parity scan");

	eventPaOff_a: assert property ((sup.pllLockLost || sup.vcoCalFail ||
		parMismatch) |=> !paEnable_reg)
		else $error("amplifier on after a failure event");

	paFollowsTx_a: assert property (paEnable_reg |->
		$past(txActive_reg))
		else $error("amplifier on without an active transmitter");

	lbdQuiet_a: assert property (!txActive_reg && !txStart && !sup.brownout |=>
		(statusReg & rpf_pkg::LBD_MASK) == ($past(statusReg) & rpf_pkg::LBD_MASK))
		else $error("battery flag moved while the transmitter was idle");

	lbdClear_a: assert property (txStart && !sup.brownout |=>
		(statusReg & rpf_pkg::LBD_MASK) == rpf_pkg::ZERO_BYTE)
		else $error("transmission start kept a battery flag");

	vcoClear_a: assert property (wrEn && wordIdx == rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER && !sup.vcoCalFail &&
		req.wdata[rpf_pkg::BIT_VCO] && !sup.brownout |=> !statusReg[rpf_pkg::BIT_VCO])
		else $error("calibration flag not cleared by write");

	readHold_a: assert property (!(req.sel && !req.enable && !req.write) |=>
		$stable(prdata_reg))
		else $error("read data moved outside a read setup");

	refusedWrite_a: assert property (refused_s |=>
		$stable(parMem) && $stable(mask_reg) && $stable(txActive_reg))
		else $error("refused access changed a register");

	maskWrite_a: assert property (wrEn && wordIdx == rpf_pkg::IDX_MASK && !sup.brownout |=>
		mask_reg == $past(req.wdata[7:0]))
		else $error("mask write not stored");

	ctrlWrite_a: assert property (wrEn && wordIdx == rpf_pkg::IDX_CTRL && !sup.brownout |=>
		txActive_reg == $past(req.wdata[rpf_pkg::CTRL_TX]))
		else $error("control write not stored");
endmodule
`default_nettype wire

// File: tb/rpf_host_model.sv
// Host side model: APB master issuing one register access at a time
`timescale 1ns/100ps
`default_nettype none
module rpf_host_model (
	// Clock
	input wire logic mclk,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// Each access starts on a fresh edge, so back to back calls never
	// assign the strobes twice in one time step
	task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: tb/rpf_failsafe_monitor_tb.sv
// Testbench of the register parity failsafe monitor
`timescale 1ns/100ps
`default_nettype none
module rpf_failsafe_monitor_tb;
	logic mclk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pllLockLost, vcoCalFail, brownout, lbd24Low, lbd21Low;
	logic upsetStrobe, txActive, paEnable, irq;
	logic [rpf_pkg::IDX_W-1:0] upsetIndex;
	logic [7:0] upsetBits;
	int failures, comparisons;

	rpf_host_model i_rpf_host_model (.mclk(mclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	rpf_failsafe_monitor i_rpf_failsafe_monitor (.mclk(mclk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pllLockLost(pllLockLost),
		.vcoCalFail(vcoCalFail), .brownout(brownout), .lbd24Low(lbd24Low),
		.lbd21Low(lbd21Low), .upsetStrobe(upsetStrobe), .upsetIndex(upsetIndex),
		.upsetBits(upsetBits), .txActive(txActive), .paEnable(paEnable), .irq(irq));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic complete_run();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic checkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic checkBit(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	function automatic logic [11:0] addrOf(input logic [7:0] idx);
		return {rpf_pkg::ADDR_TOP_ZERO, idx, rpf_pkg::WORD_ALIGN};
	endfunction

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		i_rpf_host_model.access(1'b1, addrOf(idx), {24'h000000, d}, rd, err);
	endtask

	task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp, input string what);
		i_rpf_host_model.access(1'b0, addrOf(idx), 32'h0000_0000, rd, err);
		checkWord(rd, {24'h000000, exp}, what);
	endtask

	// Order: pll, vco, brownout, lbd24, lbd21; checks land after the sampling edge
	task automatic pulseEv(input logic [4:0] ev);
		@(posedge mclk);
		{pllLockLost, vcoCalFail, brownout, lbd24Low, lbd21Low} <= ev;
		@(posedge mclk);
		{pllLockLost, vcoCalFail, brownout, lbd24Low, lbd21Low} <= 5'h00;
		#1;
	endtask

	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		complete_run();
	end

	initial begin
		failures = 0;
		comparisons = 0;
		reset = 1'b1;
		{pllLockLost, vcoCalFail, brownout, lbd24Low, lbd21Low} = 5'h00;
		upsetStrobe = 1'b0;
		upsetIndex = 3'h0;
		upsetBits = 8'h00;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		#1;
		checkBit(paEnable, 1'b0, "amplifier after reset");
		checkBit(irq, 1'b0, "irq after reset");
		rdChk(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'h84, "status after reset");
		checkBit(err, 1'b0, "mapped read error flag");
		wr(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'h04);
		rdChk(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'h80, "brownout cleared");
		wr(rpf_pkg::IDX_CFG0, 8'h07);
		wr(rpf_pkg::IDX_CFG0 + 8'h01, 8'h03);
		rdChk(rpf_pkg::IDX_PARITY, 8'h01, "stored parity");
		wr(rpf_pkg::IDX_MASK, 8'h01);
		rdChk(rpf_pkg::IDX_MASK, 8'h01, "mask readback");
		pulseEv(5'b10000);
		checkBit(irq, 1'b1, "irq on lock loss");
		rdChk(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'h81, "lock loss flag");
		wr(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'h01);
		#1;
		checkBit(irq, 1'b0, "irq after clear");
		wr(rpf_pkg::IDX_CTRL, 8'h01);
		@(posedge mclk);
		#1;
		checkBit(txActive, 1'b1, "transmitter started");
		checkBit(paEnable, 1'b1, "amplifier on");
		pulseEv(5'b01000);
		checkBit(paEnable, 1'b0, "amplifier off on calibration fail");
		rdChk(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'h88, "calibration flag");
		wr(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'h08);
		repeat (2) @(posedge mclk);
		#1;
		checkBit(paEnable, 1'b1, "amplifier back on");
		// Fault injection flips a stored bit behind the parity's back
		@(posedge mclk);
		upsetStrobe <= 1'b1;
		upsetBits <= 8'h01;
		@(posedge mclk);
		upsetStrobe <= 1'b0;
		repeat (20) begin
			@(posedge mclk);
			#1;
			if (paEnable === 1'b0) break;
		end
		checkBit(paEnable, 1'b0, "amplifier off on parity error");
		rdChk(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'h82, "parity flag");
		rdChk(rpf_pkg::IDX_CFG0, 8'h06, "upset content");
		rdChk(rpf_pkg::IDX_PARITY, 8'h01, "parity kept");
		pulseEv(5'b00010);
		pulseEv(5'b00001);
		wr(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'h30);
		rdChk(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'hB2, "battery low flags");
		// A fresh start drops the battery flags; the parity flag is sticky
		wr(rpf_pkg::IDX_CTRL, 8'h00);
		wr(rpf_pkg::IDX_CTRL, 8'h01);
		rdChk(rpf_pkg::IDX_CTRL, 8'h01, "transmitter control");
		rdChk(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'h82, "battery flags cleared on start");
		pulseEv(5'b00100);
		checkBit(paEnable, 1'b0, "amplifier off on brownout");
		checkBit(txActive, 1'b0, "restart after brownout");
		rdChk(rpf_pkg::IDX_TRANSMITTER_STATUS_REGISTER, 8'h84, "brownout flag");
		rdChk(rpf_pkg::IDX_CFG0, 8'h00, "config reset");
		rdChk(rpf_pkg::IDX_PARITY, 8'h00, "parity reset");
		rdChk(rpf_pkg::IDX_MASK, 8'h00, "mask reset");
		i_rpf_host_model.access(1'b0, 12'h800, 32'h0000_0000, rd, err);
		checkBit(err, 1'b1, "unmapped read error");
		checkWord(rd, 32'h0000_0000, "unmapped read data");
		i_rpf_host_model.access(1'b1, 12'h041, 32'h0000_00FF, rd, err);
		checkBit(err, 1'b1, "misaligned write error");
		rdChk(rpf_pkg::IDX_CFG0, 8'h00, "misaligned write ignored");
		complete_run();
	end
endmodule
`default_nettype wire
